// ==== core/tpps_top.sv ====
/*
 * Shared test and probe pin controller: test port FSM, pin hand-over,
 * two probe pins, user pin modes and a small register_cell bank.
 * Assumes pins and foreign clocks are asynchronous to core_clk and that
 * TCK is slow enough to be sampled (at least 4 core clocks per phase).
 */
module tpps_top
   import tpps_pkg::*;
#(
   parameter int NODE_N = 16,
   parameter int CELL_N = 8
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic tms_in,
   input wire logic tck_in,
   output logic tck_out,
   output logic tck_oe_n,
   input wire logic tdi_in,
   output logic tdi_out,
   output logic tdi_oe_n,
   input wire logic tdo_in,
   output logic tdo_out,
   output logic tdo_oe_n,
   input wire logic probe_out_a_in,
   output logic probe_out_a_out,
   output logic probe_out_a_oe_n,
   input wire logic probe_out_b_in,
   output logic probe_out_b_out,
   output logic probe_out_b_oe_n,
   input wire logic dedicated_mode,
   input wire logic probe_fuse,
   input wire logic [1:0] probe_user,
   input wire logic [PIN_N*IO_MW-1:0] usr_mode,
   input wire logic [PIN_N-1:0] usr_out,
   input wire logic [PIN_N-1:0] usr_oe,
   output logic [PIN_N-1:0] usr_in,
   input wire logic [NODE_N-1:0] node_in,
   input wire logic hardwired_array_clock,
   input wire logic routed_clock_a,
   input wire logic routed_clock_b,
   input wire logic [1:0] cell_clk_sel,
   input wire logic [CELL_N-1:0] cell_d,
   output logic [CELL_N-1:0] cell_q
);
   localparam int SEL_W = $clog2(NODE_N);
   localparam int DR_W = 2 * SEL_W;

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers; edges come from stage two only
   logic [SY_W-1:0] raw, sy1_q, sy2_q;
   logic tck_p_q, hck_p_q, rca_p_q, rcb_p_q;
   logic [PIN_N-1:0] pin_s;
   logic tms_s, tdi_s, ded_s, fuse_s;
   logic tck_r, tck_f, hck_r, rca_r, rcb_r;

   assign raw = {probe_fuse, dedicated_mode, hardwired_array_clock,
                 routed_clock_a, routed_clock_b, probe_out_b_in,
                 probe_out_a_in, tdo_in, tdi_in, tck_in, tms_in};
   assign pin_s = sy2_q[SY_PIN +: PIN_N];
   assign tms_s = sy2_q[SY_TMS];
   assign tdi_s = pin_s[P_TDI];
   assign ded_s = sy2_q[SY_DED];
   assign fuse_s = sy2_q[SY_FUSE];
   assign tck_r = pin_s[P_TCK] & ~tck_p_q;
   assign tck_f = ~pin_s[P_TCK] & tck_p_q;
   assign hck_r = sy2_q[SY_HCK] & ~hck_p_q;
   assign rca_r = sy2_q[SY_RCA] & ~rca_p_q;
   assign rcb_r = sy2_q[SY_RCB] & ~rcb_p_q;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sy1_q <= SY_IDLE;
         sy2_q <= SY_IDLE;
         tck_p_q <= 1'b0;
         hck_p_q <= 1'b0;
         rca_p_q <= 1'b0;
         rcb_p_q <= 1'b0;
      end else begin
         sy1_q <= raw;
         sy2_q <= sy1_q;
         tck_p_q <= pin_s[P_TCK];
         hck_p_q <= sy2_q[SY_HCK];
         rca_p_q <= sy2_q[SY_RCA];
         rcb_p_q <= sy2_q[SY_RCB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Test port FSM, instruction and data paths, pin ownership
   tpps_tap_e tap_q, tap_d;
   logic [IR_W-1:0] ir_q, ir_d, irs_q, irs_d;
   logic [DR_W-1:0] dr_q, dr_d;
   logic [SEL_W-1:0] sa_q, sa_d, sb_q, sb_d;
   logic bp_q, bp_d, tdo_q, tdo_d, act_q, act_d, lock_q, lock_d;

   always_comb begin
      tap_d = tap_q;
      ir_d = ir_q;
      irs_d = irs_q;
      dr_d = dr_q;
      bp_d = bp_q;
      sa_d = sa_q;
      sb_d = sb_q;
      tdo_d = tdo_q;
      // Sticky until reset; the fuse input itself may return low
      lock_d = lock_q | fuse_s;
      if (act_q && tck_r) begin
         tap_d = tap_next(tap_q, tms_s);
         case (tap_q)
            S_TLR: ir_d = IR_BYP;
            S_CAPIR: irs_d = IR_CAPT;
            S_SHIR: irs_d = {tdi_s, irs_q[IR_W-1:1]};
            S_UPIR: ir_d = irs_q;
            S_CAPDR: begin
               bp_d = 1'b0;
               dr_d = (ir_q == IR_PROBE) ? {sb_q, sa_q} : DR_W'(pin_s);
            end
            S_SHDR: begin
               bp_d = tdi_s;
               dr_d = {tdi_s, dr_q[DR_W-1:1]};
            end
            S_UPDR: begin
               if (ir_q == IR_PROBE) begin
                  sa_d = dr_q[SEL_W-1:0];
                  sb_d = dr_q[DR_W-1:SEL_W];
               end
            end
            default: ;
         endcase
      end
      // TDO changes on the falling TCK edge so the tester samples it stable
      if (act_q && tck_f) begin
         if (tap_q == S_SHIR) begin
            tdo_d = irs_q[0];
         end else if (tap_q == S_SHDR) begin
            tdo_d = (ir_q == IR_BYP) ? bp_q : dr_q[0];
         end
      end
      if (ded_s) begin
         act_d = 1'b1;
      end else if (act_q) begin
         act_d = !(tap_d == S_TLR && tap_q != S_TLR);
      end else begin
         act_d = !tms_s;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         tap_q <= S_TLR;
         ir_q <= IR_BYP;
         irs_q <= '0;
         dr_q <= '0;
         bp_q <= 1'b0;
         sa_q <= '0;
         sb_q <= '0;
         tdo_q <= 1'b0;
         act_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         tap_q <= tap_d;
         ir_q <= ir_d;
         irs_q <= irs_d;
         dr_q <= dr_d;
         bp_q <= bp_d;
         sa_q <= sa_d;
         sb_q <= sb_d;
         tdo_q <= tdo_d;
         act_q <= act_d;
         lock_q <= lock_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers
   logic [PIN_N-1:0] out_q, out_d, oen_q, oen_d, uin_q, uin_d;

   always_comb begin
      tpps_mode_t md;
      md = IO_UNUSED;
      for (int i = 0; i < PIN_N; i++) begin
         md = usr_mode[i*IO_MW +: IO_MW];
         out_d[i] = usr_out[i];
         oen_d[i] = io_oe_n(md, usr_oe[i]);
         uin_d[i] = io_rd(md) & pin_s[i];
      end
      if (act_q) begin
         oen_d[P_TCK] = 1'b1;
         oen_d[P_TDI] = 1'b1;
         out_d[P_TDO] = tdo_q;
         oen_d[P_TDO] = 1'b0;
         uin_d[P_TDO:P_TCK] = '0;
      end
      // A locked probe pin floats while not in user use and never shows the node value
      if (!probe_user[0]) begin
         out_d[P_PRA] = node_in[sa_q] & ~lock_q;
         oen_d[P_PRA] = lock_q;
         uin_d[P_PRA] = 1'b0;
      end
      if (!probe_user[1]) begin
         out_d[P_PRB] = node_in[sb_q] & ~lock_q;
         oen_d[P_PRB] = lock_q;
         uin_d[P_PRB] = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         out_q <= '0;
         oen_q <= '1;
         uin_q <= '0;
      end else begin
         out_q <= out_d;
         oen_q <= oen_d;
         uin_q <= uin_d;
      end
   end

   assign tck_out = out_q[P_TCK];
   assign tck_oe_n = oen_q[P_TCK];
   assign tdi_out = out_q[P_TDI];
   assign tdi_oe_n = oen_q[P_TDI];
   assign tdo_out = out_q[P_TDO];
   assign tdo_oe_n = oen_q[P_TDO];
   assign probe_out_a_out = out_q[P_PRA];
   assign probe_out_a_oe_n = oen_q[P_PRA];
   assign probe_out_b_out = out_q[P_PRB];
   assign probe_out_b_oe_n = oen_q[P_PRB];
   assign usr_in = uin_q;

   ////////////////////////////////////////////////////////////////////////
   // register_cell bank; routed clocks cost one distribution stage
   logic rdist_q, rdist_d;
   logic [CELL_N-1:0] cq_q, cq_d;

   always_comb begin
      rdist_d = (cell_clk_sel == CK_RA && rca_r) ||
                (cell_clk_sel == CK_RB && rcb_r);
      cq_d = cq_q;
      if ((cell_clk_sel == CK_HW && hck_r) || rdist_q) begin
         cq_d = cell_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rdist_q <= 1'b0;
         cq_q <= '0;
      end else begin
         rdist_q <= rdist_d;
         cq_q <= cq_d;
      end
   end

   assign cell_q = cq_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [2:0] hi_cnt_q;

   always_ff @(posedge core_clk) begin
      if (!reset_n || !act_q) begin
         hi_cnt_q <= '0;
      end else if (tck_r) begin
         if (!tms_s) begin
            hi_cnt_q <= '0;
         end else if (hi_cnt_q != 3'(TLR_HOLD)) begin
            hi_cnt_q <= hi_cnt_q + 3'h1;
         end
      end
   end

   property p_take;
      @(posedge core_clk) disable iff (!reset_n)
      !act_q && !ded_s && !tms_s |=> act_q ##1 tck_oe_n && !tdo_oe_n;
   endproperty
   a_take: assert property (p_take)
      else $error("low TMS did not claim the scan pins");

   property p_hold;
      @(posedge core_clk) disable iff (!reset_n)
      act_q && !(tap_d == S_TLR && tap_q != S_TLR) |=> act_q;
   endproperty
   a_hold: assert property (p_hold)
      else $error("scan pins released outside logic reset");

   property p_five;
      @(posedge core_clk) disable iff (!reset_n)
      hi_cnt_q == 3'(TLR_HOLD) |-> tap_q == S_TLR;
   endproperty
   a_five: assert property (p_five)
      else $error("five TMS-high clocks did not reach logic reset");

   property p_release;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(tap_q == S_TLR) && !ded_s |-> !act_q ##1 tdo_oe_n ==
         $past(io_oe_n(usr_mode[P_TDO*IO_MW +: IO_MW], usr_oe[P_TDO]));
   endproperty
   a_release: assert property (p_release)
      else $error("scan pins not returned to user I/O");

   property p_ded;
      @(posedge core_clk) disable iff (!reset_n)
      ded_s |=> act_q;
   endproperty
   a_ded: assert property (p_ded)
      else $error("dedicated mode lost the test port");

   property p_sel;
      @(posedge core_clk) disable iff (!reset_n)
      act_q && tck_r && tap_q == S_UPDR && ir_q == IR_PROBE
         |=> sa_q == $past(dr_q[SEL_W-1:0]);
   endproperty
   a_sel: assert property (p_sel)
      else $error("probe selection not loaded from scan data");

   property p_tdo;
      @(posedge core_clk) disable iff (!reset_n)
      act_q |=> !tdo_oe_n && tdo_out == $past(tdo_q);
   endproperty
   a_tdo: assert property (p_tdo)
      else $error("TDO not driven in test use");

   property p_pra;
      @(posedge core_clk) disable iff (!reset_n)
      !probe_user[0] && !lock_q
         |=> !probe_out_a_oe_n && probe_out_a_out == $past(node_in[sa_q]);
   endproperty
   a_pra: assert property (p_pra)
      else $error("probe A does not show the selected node");

   property p_prb;
      @(posedge core_clk) disable iff (!reset_n)
      !probe_user[1] && !lock_q
         |=> !probe_out_b_oe_n && probe_out_b_out == $past(node_in[sb_q]);
   endproperty
   a_prb: assert property (p_prb)
      else $error("probe B does not show the selected node");

   property p_puser;
      @(posedge core_clk) disable iff (!reset_n)
      probe_user[1] && usr_mode[P_PRB*IO_MW +: IO_MW] == IO_OUT
         |=> !probe_out_b_oe_n && probe_out_b_out == $past(usr_out[P_PRB]);
   endproperty
   a_puser: assert property (p_puser)
      else $error("probe B not usable as user output");

   property p_lock;
      @(posedge core_clk) disable iff (!reset_n)
      lock_q |=> lock_q && (probe_user[0] || probe_out_a_oe_n);
   endproperty
   a_lock: assert property (p_lock)
      else $error("probe disable did not hold");

   property p_hclk;
      @(posedge core_clk) disable iff (!reset_n)
      hck_r && cell_clk_sel == CK_HW |=> cell_q == $past(cell_d);
   endproperty
   a_hclk: assert property (p_hclk)
      else $error("hardwired clock did not load the cells");

   property p_rclk;
      @(posedge core_clk) disable iff (!reset_n)
      rca_r && cell_clk_sel == CK_RA |=> ##1 cell_q == $past(cell_d);
   endproperty
   a_rclk: assert property (p_rclk)
      else $error("routed clock did not load the cells after one stage");

   property p_unused;
      @(posedge core_clk) disable iff (!reset_n)
      !act_q && usr_mode[P_TCK*IO_MW +: IO_MW] == IO_UNUSED |=> tck_oe_n;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused pin is driven");

   property p_fsm;
      @(posedge core_clk) disable iff (!reset_n)
      act_q && tck_r && tap_q == S_TLR && !tms_s |=> tap_q == S_RTI;
   endproperty
   a_fsm: assert property (p_fsm)
      else $error("test FSM left logic reset wrongly");
endmodule

// ==== inc/tpps_pkg.sv ====
/*
 * Shared constants, types and helpers for the test and probe pin sharing
 * block. Assumes a single core clock; every pin signal is synchronised
 * in the top module before use.
 */
package tpps_pkg;
   // Synchroniser vector layout
   localparam int SY_W = 11;
   localparam int SY_TMS = 0;
   localparam int SY_PIN = 1;
   localparam int SY_RCB = 6;
   localparam int SY_RCA = 7;
   localparam int SY_HCK = 8;
   localparam int SY_DED = 9;
   localparam int SY_FUSE = 10;
   // Synchroniser reset value: TMS idles high so reset cannot fake a claim
   localparam logic [SY_W-1:0] SY_IDLE = SY_W'(1) << SY_TMS;
   // Shared pin indices
   localparam int PIN_N = 5;
   localparam int P_TCK = 0;
   localparam int P_TDI = 1;
   localparam int P_TDO = 2;
   localparam int P_PRA = 3;
   localparam int P_PRB = 4;
   localparam int TLR_HOLD = 5;
   localparam int IR_W = 2;
   localparam logic [IR_W-1:0] IR_SAMPLE = 2'h0;
   localparam logic [IR_W-1:0] IR_CAPT = 2'h1;
   localparam logic [IR_W-1:0] IR_PROBE = 2'h2;
   localparam logic [IR_W-1:0] IR_BYP = 2'h3;
   localparam int IO_MW = 3;
   typedef logic [IO_MW-1:0] tpps_mode_t;
   localparam tpps_mode_t IO_UNUSED = 3'h0;
   localparam tpps_mode_t IO_IN = 3'h1;
   localparam tpps_mode_t IO_OUT = 3'h2;
   localparam tpps_mode_t IO_TRI = 3'h3;
   localparam tpps_mode_t IO_BIDIR = 3'h4;
   localparam logic [1:0] CK_HW = 2'h0;
   localparam logic [1:0] CK_RA = 2'h1;
   localparam logic [1:0] CK_RB = 2'h2;

   typedef enum logic [15:0] {
      S_TLR = 16'h0001, S_RTI = 16'h0002, S_SELDR = 16'h0004,
      S_CAPDR = 16'h0008, S_SHDR = 16'h0010, S_EX1DR = 16'h0020,
      S_PSDR = 16'h0040, S_EX2DR = 16'h0080, S_UPDR = 16'h0100,
      S_SELIR = 16'h0200, S_CAPIR = 16'h0400, S_SHIR = 16'h0800,
      S_EX1IR = 16'h1000, S_PSIR = 16'h2000, S_EX2IR = 16'h4000,
      S_UPIR = 16'h8000
   } tpps_tap_e;

   function automatic tpps_tap_e tap_next(tpps_tap_e st, logic tms);
      case (st)
         S_TLR: tap_next = tms ? S_TLR : S_RTI;
         S_RTI: tap_next = tms ? S_SELDR : S_RTI;
         S_SELDR: tap_next = tms ? S_SELIR : S_CAPDR;
         S_CAPDR: tap_next = tms ? S_EX1DR : S_SHDR;
         S_SHDR: tap_next = tms ? S_EX1DR : S_SHDR;
         S_EX1DR: tap_next = tms ? S_UPDR : S_PSDR;
         S_PSDR: tap_next = tms ? S_EX2DR : S_PSDR;
         S_EX2DR: tap_next = tms ? S_UPDR : S_SHDR;
         S_UPDR: tap_next = tms ? S_SELDR : S_RTI;
         S_SELIR: tap_next = tms ? S_TLR : S_CAPIR;
         S_CAPIR: tap_next = tms ? S_EX1IR : S_SHIR;
         S_SHIR: tap_next = tms ? S_EX1IR : S_SHIR;
         S_EX1IR: tap_next = tms ? S_UPIR : S_PSIR;
         S_PSIR: tap_next = tms ? S_EX2IR : S_PSIR;
         S_EX2IR: tap_next = tms ? S_UPIR : S_SHIR;
         S_UPIR: tap_next = tms ? S_SELDR : S_RTI;
         default: tap_next = S_TLR;
      endcase
   endfunction

   // Output enable, active low, of a user pin in a given mode
   function automatic logic io_oe_n(tpps_mode_t md, logic oe);
      case (md)
         IO_OUT: io_oe_n = 1'b0;
         IO_TRI, IO_BIDIR: io_oe_n = ~oe;
         default: io_oe_n = 1'b1;
      endcase
   endfunction

   function automatic logic io_rd(tpps_mode_t md);
      io_rd = (md == IO_IN) || (md == IO_BIDIR);
   endfunction
endpackage

// ==== tb/tpps_tester.sv ====
/*
 * Behavioural test controller on the far side of the shared scan pins.
 * Assumes the bench resolves the pin levels and returns the TDO level.
 */
module tpps_tester (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   timeunit 1ns;
   timeprecision 1ps;
   int slow = 0;

   // TCK stands low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // TDO is taken late in the high phase, after the device's slow update
   task automatic clk(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #(160 + slow) tck = 1'b1;
      #150 q = tdo;
      #10 tck = 1'b0;
   endtask

   // From idle through capture, n shifts and update back to idle
   task automatic scan(input logic ir, input int n, input logic [7:0] din,
         output logic [7:0] dout);
      logic q;
      dout = 8'h00;
      clk(1'b1, 1'b0, q);
      if (ir) clk(1'b1, 1'b0, q);
      clk(1'b0, 1'b0, q);
      clk(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         clk(i == n - 1, din[i], q);
         dout[i] = q;
      end
      clk(1'b1, 1'b0, q);
      clk(1'b0, 1'b0, q);
   endtask

   task automatic claim;
      tms = 1'b0;
   endtask

   task automatic go_reset(input int n);
      logic q;
      repeat (n) clk(1'b1, 1'b0, q);
   endtask
endmodule

// ==== tb/tpps_top_test.sv ====
/*
 * Self-checking bench of the shared test and probe pin block.
 * Assumes the tester model drives TMS, TCK and TDI; pin levels are
 * resolved here from every party's enable.
 */
module tpps_top_test;
   import tpps_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, reset_n, dedicated_mode, probe_fuse, jt_on, o;
   logic [1:0] probe_user, cell_clk_sel;
   logic [PIN_N*IO_MW-1:0] usr_mode;
   logic [PIN_N-1:0] usr_out, usr_oe, ext;
   logic [15:0] node_in;
   logic [2:0] ck;
   logic [7:0] cell_d, r, s;
   wire [PIN_N-1:0] oe_n_v, out_v, lvl, usr_in;
   wire [7:0] cell_q;
   wire j_tck, j_tms, j_tdi;
   int failures = 0;
   int checks = 0;
   int seed = 61;
   int lat[4];

   tpps_top u_dut (
      .core_clk(core_clk), .reset_n(reset_n), .tms_in(j_tms),
      .tck_in(lvl[0]), .tck_out(out_v[0]), .tck_oe_n(oe_n_v[0]),
      .tdi_in(lvl[1]), .tdi_out(out_v[1]), .tdi_oe_n(oe_n_v[1]),
      .tdo_in(lvl[2]), .tdo_out(out_v[2]), .tdo_oe_n(oe_n_v[2]),
      .probe_out_a_in(lvl[3]), .probe_out_a_out(out_v[3]),
      .probe_out_a_oe_n(oe_n_v[3]), .probe_out_b_in(lvl[4]),
      .probe_out_b_out(out_v[4]), .probe_out_b_oe_n(oe_n_v[4]),
      .dedicated_mode(dedicated_mode), .probe_fuse(probe_fuse),
      .probe_user(probe_user), .usr_mode(usr_mode), .usr_out(usr_out),
      .usr_oe(usr_oe), .usr_in(usr_in), .node_in(node_in),
      .hardwired_array_clock(ck[0]), .routed_clock_a(ck[1]),
      .routed_clock_b(ck[2]), .cell_clk_sel(cell_clk_sel),
      .cell_d(cell_d), .cell_q(cell_q)
   );
   tpps_tester u_jtag (.tck(j_tck), .tms(j_tms), .tdi(j_tdi), .tdo(lvl[2]));

   // Device drive wins; undriven TCK and TDI show the tester once jt_on is set, any other undriven pin the bench's own pattern
   assign lvl[0] = !oe_n_v[0] ? out_v[0] : (jt_on ? j_tck : ext[0]);
   assign lvl[1] = !oe_n_v[1] ? out_v[1] : (jt_on ? j_tdi : ext[1]);
   assign lvl[4:2] = (~oe_n_v[4:2] & out_v[4:2]) | (oe_n_v[4:2] & ext[4:2]);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic x_oe_n(logic [2:0] m, logic oe);
      if (m == IO_OUT) return 1'b0;
      if (m == IO_TRI || m == IO_BIDIR) return !oe;
      return 1'b1;
   endfunction

   function automatic logic x_rd(logic [2:0] m);
      return m == IO_IN || m == IO_BIDIR;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
         input logic [15:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask

   task automatic end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic do_reset;
      @(posedge core_clk);
      reset_n <= 1'b0;
      cyc(10);
      chk("reset oe_n", 16'h001F, oe_n_v);
      chk("reset out", 16'h0000, out_v);
      chk("reset usr_in", 16'h0000, usr_in);
      chk("reset cell_q", 16'h0000, cell_q);
      reset_n <= 1'b1;
   endtask

   // Cycles from a clock pin rise to the cell taking its data
   task automatic cell_lat(input int sel, output int n);
      @(posedge core_clk);
      cell_clk_sel <= sel[1:0];
      cell_d <= ~cell_q;
      cyc(1);
      ck <= (sel == 3) ? 3'h7 : 3'h1 << sel;
      n = 0;
      while (cell_q !== cell_d && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
      ck <= 3'h0;
      cyc(4);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   initial begin
      #200000;
      failures++;
      $display("Error watchdog expected finish seen timeout");
      end_of_test();
   end

   initial begin
      logic [2:0] m;
      logic e;
      reset_n = 1'b0;
      dedicated_mode = 1'b0;
      probe_fuse = 1'b0;
      probe_user = 2'h3;
      cell_clk_sel = 2'h3;
      usr_mode = {PIN_N{IO_OUT}};
      usr_out = 5'h1F;
      usr_oe = 5'h1F;
      ext = 5'h0A;
      node_in = 16'h0000;
      ck = 3'h0;
      cell_d = 8'h00;
      jt_on = 1'b0;
      do_reset();
      cyc(3);
      done("reset");
      // Every mode code on every pin first, then mixed random modes
      for (int k = 0; k < 10; k++) begin
         @(posedge core_clk);
         for (int i = 0; i < PIN_N; i++) begin
            r = 8'($random(seed));
            usr_mode[i*IO_MW +: IO_MW] <= (k < 5) ? 3'(k) : r[2:0];
         end
         usr_out <= 5'($random(seed));
         usr_oe <= 5'($random(seed));
         ext <= 5'($random(seed));
         cyc(5);
         for (int i = 0; i < PIN_N; i++) begin
            m = usr_mode[i*IO_MW +: IO_MW];
            e = x_oe_n(m, usr_oe[i]);
            chk("pin oe_n", e, oe_n_v[i]);
            if (!e) chk("pin out", usr_out[i], out_v[i]);
            chk("usr_in", x_rd(m) & (e ? ext[i] : usr_out[i]), usr_in[i]);
         end
      end
      done("user pins");
      @(posedge core_clk);
      usr_mode <= {PIN_N{IO_OUT}};
      usr_oe <= 5'h1F;
      probe_user <= 2'h0;
      jt_on <= 1'b1;
      cyc(4);
      chk("user scan pins", 16'h0000, oe_n_v[2:0]);
      u_jtag.claim();
      cyc(8);
      chk("claim oe_n", 16'h0003, oe_n_v[2:0]);
      chk("claim usr_in", 16'h0000, usr_in[2:0]);
      u_jtag.clk(1'b0, 1'b0, o);
      u_jtag.scan(1'b1, 2, 8'h02, r);
      chk("ir capture", 16'h0001, r);
      s = 8'($random(seed));
      u_jtag.scan(1'b0, 8, s, r);
      chk("dr capture", 16'h0000, r);
      u_jtag.slow = 400;
      u_jtag.scan(1'b0, 8, ~s, r);
      u_jtag.slow = 0;
      chk("dr readback", s, r);
      s = ~s;
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         node_in <= 16'($random(seed));
         cyc(3);
         chk("probe a", node_in[s[3:0]], out_v[3]);
         chk("probe b", node_in[s[7:4]], out_v[4]);
         chk("probe oe_n", 16'h0000, oe_n_v[4:3]);
      end
      u_jtag.scan(1'b1, 2, 8'h03, r);
      r = 8'($random(seed));
      u_jtag.scan(1'b0, 8, r, s);
      chk("bypass", {r[6:0], 1'b0}, s);
      done("scan");
      u_jtag.clk(1'b1, 1'b0, o);
      u_jtag.clk(1'b0, 1'b0, o);
      u_jtag.clk(1'b0, 1'b0, o);
      u_jtag.go_reset(4);
      cyc(8);
      chk("held oe_n", 16'h0003, oe_n_v[2:0]);
      u_jtag.go_reset(1);
      cyc(8);
      chk("released oe_n", 16'h0000, oe_n_v[2:0]);
      chk("released out", usr_out[2:0], out_v[2:0]);
      done("release");
      @(posedge core_clk);
      probe_fuse <= 1'b1;
      cyc(6);
      chk("lock oe_n", 16'h0003, oe_n_v[4:3]);
      chk("lock out", 16'h0000, out_v[4:3]);
      probe_fuse <= 1'b0;
      cyc(6);
      chk("lock sticky", 16'h0003, oe_n_v[4:3]);
      done("fuse");
      for (int k = 0; k < 4; k++) cell_lat(k, lat[k]);
      chk("hardwired taken", 16'h0001, 16'(lat[0] < 8));
      chk("routed a", 16'(lat[0] + 1), 16'(lat[1]));
      chk("routed b", 16'(lat[0] + 1), 16'(lat[2]));
      chk("no clock", 16'd20, 16'(lat[3]));
      done("cells");
      dedicated_mode <= 1'b1;
      do_reset();
      cyc(8);
      chk("dedicated oe_n", 16'h0003, oe_n_v[2:0]);
      u_jtag.go_reset(5);
      cyc(8);
      chk("dedicated kept", 16'h0003, oe_n_v[2:0]);
      u_jtag.clk(1'b0, 1'b0, o);
      u_jtag.scan(1'b1, 2, 8'h02, r);
      chk("dedicated ir", 16'h0001, r);
      done("dedicated");
      end_of_test();
   end
endmodule
